// >>> inc/pio_pkg.sv
// Shared constants, register map and types of the pump I/O and phase sequencer
package pio_pkg;
  // Timing
  localparam int CLK_NS   = 25;
  localparam int DEB_NS   = 100000;
  localparam int DEB_CYC  = (DEB_NS + CLK_NS - 1) / CLK_NS;
  localparam int TICK_NS  = 1000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int BEEP_NS  = 50000000;
  localparam logic [11:0] DEB_LAST  = 12'(DEB_CYC - 1);
  localparam logic [5:0]  TICK_LAST = 6'(TICK_CYC - 1);
  // Phase range
  localparam int PH_MAX = 41;
  localparam logic [5:0] PH_LAST  = 6'(PH_MAX);
  localparam logic [5:0] PH_FIRST = 6'h01;
  // Register byte offsets
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_KEY   = 8'h04;
  localparam logic [7:0] A_PSEL  = 8'h08;
  localparam logic [7:0] A_PDATA = 8'h0C;
  localparam logic [7:0] A_STAT  = 8'h10;
  localparam logic [7:0] A_CMD   = 8'h14;
  // Settings fields (CTRL and KEY)
  localparam int F_DIRCFG = 0;
  localparam int F_MMODE  = 1;
  localparam int F_LOCK   = 2;
  localparam int F_BEEP   = 3;
  localparam int F_COMM   = 4;
  localparam int F_BAUD   = 8;
  localparam int F_STN    = 16;
  localparam logic [6:0] STN_MAX  = 7'h63;
  localparam logic [2:0] BAUD_MAX = 3'h4;
  localparam logic [2:0] BAUD_RST = 3'h4;
  // Program entry fields
  localparam int ENT_W   = 31;
  localparam int E_RATE  = 0;
  localparam int E_PAR   = 16;
  localparam int E_DIR   = 24;
  localparam int E_FUNC  = 28;
  localparam logic [2:0] FN_RATE  = 3'h0;
  localparam logic [2:0] FN_STOP  = 3'h1;
  localparam logic [2:0] FN_JUMP  = 3'h2;
  localparam logic [2:0] FN_PAUSE = 3'h3;
  localparam logic [2:0] FN_PRSEL = 3'h4;
  // Status and command fields
  localparam int S_ST    = 0;
  localparam int S_PH    = 8;
  localparam int S_DIR   = 16;
  localparam int S_MOTOR = 17;
  localparam int S_LKIND = 18;
  localparam int S_PLUG  = 19;
  localparam int S_ENDED = 20;
  localparam int S_BEEP  = 21;
  localparam int C_START = 0;
  localparam int C_STOP  = 1;
  localparam int C_SEL   = 2;
  localparam int C_LABEL = 8;
  typedef enum logic [2:0] {
    ST_BOOT  = 3'h0,
    ST_IDLE  = 3'h1,
    ST_FETCH = 3'h2,
    ST_EXEC  = 3'h3,
    ST_PUMP  = 3'h4,
    ST_PAUSE = 3'h5,
    ST_WAIT  = 3'h6
  } pio_state_t;
  typedef enum logic [1:0] {
    COMM_ADDR  = 2'h0,
    COMM_RECIP = 2'h1,
    COMM_DUAL  = 2'h2,
    COMM_ALT   = 2'h3
  } pio_comm_t;
endpackage

// >>> logic/pio_phase_mem.sv
// Retained phase program store, one entry per phase, registered read
`timescale 1ns/10ps
module pio_phase_mem (
  input  wire logic                     core_clk_i, // Core clock
  input  wire logic                     rst_i,      // Sync reset, read register only
  input  wire logic                     we_i,       // Write strobe
  input  wire logic [5:0]               waddr_i,    // Write phase
  input  wire logic [pio_pkg::ENT_W-1:0] wdata_i,   // Write entry
  input  wire logic [5:0]               raddr_i,    // Read phase
  output logic      [pio_pkg::ENT_W-1:0] rdata_o    // Registered read entry
);
  logic [pio_pkg::ENT_W-1:0] mem_r [0:pio_pkg::PH_MAX];

  // Array keeps its content through reset
  always_ff @(posedge core_clk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  // Registered read port
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem_r[raddr_i];
    end
  end
endmodule

// >>> logic/pio_top.sv
// Pump I/O configuration, lockout, beeper, network settings and phase sequencer
`timescale 1ns/10ps
module pio_top #(
  parameter int BEEP_CYC = pio_pkg::BEEP_NS / pio_pkg::CLK_NS
) (
  input  wire logic        core_clk_i,   // 40 MHz core clock
  input  wire logic        rst_i,        // Sync reset, active high
  input  wire logic        hsel_i,       // AHB select
  input  wire logic [31:0] haddr_i,      // AHB address
  input  wire logic [1:0]  htrans_i,     // AHB transfer type
  input  wire logic        hwrite_i,     // AHB write
  input  wire logic [2:0]  hsize_i,      // AHB size, words only
  input  wire logic [31:0] hwdata_i,     // AHB write data
  input  wire logic        hready_i,     // AHB ready in
  output logic      [31:0] hrdata_o,     // AHB read data
  output logic             hreadyout_o,  // AHB ready out
  output logic             hresp_o,      // AHB response, always OKAY
  input  wire logic        dir_pin_i,    // Direction control pin
  input  wire logic        prog_in_n_i,  // Program input pin, low with key plug
  input  wire logic        lock_strap_i, // Retained lockout enable at power-up
  input  wire logic        phase_done_i, // Motor finished current pumping phase
  output logic             motor_run_o,  // Motor operating output
  output logic             beep_o,       // Buzzer drive
  output logic             dir_o,        // Pumping direction, 1 withdraw
  output logic      [15:0] rate_o,       // Current pumping rate
  output logic      [6:0]  station_o,    // Network station number
  output logic      [2:0]  baud_sel_o,   // Baud select 0..4
  output logic             sec_start_o,  // Secondary pump start pulse
  output logic             sec_stop_o,   // Secondary pump stop pulse
  output logic      [15:0] sec_rate_o,   // Rate sent to secondary pump
  output logic             sec_dir_o     // Direction sent to secondary pump
);
  pio_pkg::pio_state_t st_r;
  pio_pkg::pio_comm_t  comm_r;
  logic        ap_wr_r, dp_rd_r;
  logic [7:0]  ap_addr_r;
  logic [1:0]  db_w;
  logic [1:0]  db_prev_r;
  logic        dircfg_r, mmode_r, lock_en_r, beep_en_r, strap_done_r, lockind_r;
  logic [5:0]  psel_r, cur_r, pause_left_r, tick_r;
  logic        boot_r, start_p_r, stop_p_r, ended_r;
  logic [pio_pkg::ENT_W-1:0] ent;
  logic [21:0] beep_cnt_r;
  logic [31:0] ctrl_rd, stat_rd;

  // Clamp a phase selection into 1..41
  function automatic logic [5:0] ph_clamp(input logic [5:0] v);
    if (v > pio_pkg::PH_LAST) begin
      ph_clamp = pio_pkg::PH_LAST;
    end else if (v == 6'h00) begin
      ph_clamp = pio_pkg::PH_FIRST;
    end else begin
      ph_clamp = v;
    end
  endfunction

  // AHB address phase capture, one wait state on reads
  wire ap_take = hsel_i & htrans_i[1] & hready_i;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ap_wr_r   <= 1'b0;
      dp_rd_r   <= 1'b0;
      ap_addr_r <= 8'h00;
    end else begin
      ap_wr_r <= ap_take & hwrite_i;
      dp_rd_r <= ap_take & ~hwrite_i;
      if (ap_take) begin
        ap_addr_r <= haddr_i[7:0];
      end
    end
  end
  assign hreadyout_o = ~dp_rd_r;
  assign hresp_o     = 1'b0;

  // Write strobes in the data phase
  wire wr_ctrl  = ap_wr_r & (ap_addr_r == pio_pkg::A_CTRL);
  wire wr_key   = ap_wr_r & (ap_addr_r == pio_pkg::A_KEY);
  wire wr_psel  = ap_wr_r & (ap_addr_r == pio_pkg::A_PSEL);
  wire wr_pdata = ap_wr_r & (ap_addr_r == pio_pkg::A_PDATA);
  wire wr_stat  = ap_wr_r & (ap_addr_r == pio_pkg::A_STAT);
  wire wr_cmd   = ap_wr_r & (ap_addr_r == pio_pkg::A_CMD);
  wire cmd_start = wr_cmd & hwdata_i[pio_pkg::C_START];
  wire cmd_stop  = wr_cmd & hwdata_i[pio_pkg::C_STOP];
  wire cmd_sel   = wr_cmd & hwdata_i[pio_pkg::C_SEL];

  genvar g;
  for (g = 0; g < 2; g++) begin : g_deb
    logic s1_r, s2_r, db_r;
    logic [11:0] cnt_r;
    wire raw = g ? prog_in_n_i : dir_pin_i;
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        s1_r  <= 1'b1;
        s2_r  <= 1'b1;
        db_r  <= 1'b1;
        cnt_r <= 12'h000;
      end else begin
        s1_r <= raw;
        s2_r <= s1_r;
        if (s2_r == db_r) begin
          cnt_r <= 12'h000;
        end else if (cnt_r == pio_pkg::DEB_LAST) begin
          db_r  <= s2_r;
          cnt_r <= 12'h000;
        end else begin
          cnt_r <= cnt_r + 12'h001;
        end
      end
    end
    assign db_w[g] = db_r;
  end

  // Debounced level history for edge detection
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      db_prev_r <= 2'h3;
    end else begin
      db_prev_r <= db_w;
    end
  end
  wire dir_fall = db_prev_r[0] & ~db_w[0];
  wire dir_rise = ~db_prev_r[0] & db_w[0];
  // grounded program input is the key plug
  wire plug   = ~db_w[1];
  wire locked = lock_en_r & ~plug;
  wire set_we = wr_ctrl | (wr_key & ~locked);

  // Settings registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      dircfg_r     <= 1'b0;
      mmode_r      <= 1'b0;
      lock_en_r    <= 1'b0;
      beep_en_r    <= 1'b0;
      comm_r       <= pio_pkg::COMM_ADDR;
      baud_sel_o   <= pio_pkg::BAUD_RST;
      station_o    <= 7'h00;
      strap_done_r <= 1'b0;
    end else begin
      if (!strap_done_r) begin
        lock_en_r    <= lock_strap_i;
        strap_done_r <= 1'b1;
      end
      if (set_we) begin
        dircfg_r  <= hwdata_i[pio_pkg::F_DIRCFG];
        mmode_r   <= hwdata_i[pio_pkg::F_MMODE];
        beep_en_r <= hwdata_i[pio_pkg::F_BEEP];
        comm_r    <= pio_pkg::pio_comm_t'(hwdata_i[pio_pkg::F_COMM +: 2]);
        // keypad alters lockout enable only with plug in
        if (wr_ctrl | plug) begin
          lock_en_r <= hwdata_i[pio_pkg::F_LOCK];
        end
        if (hwdata_i[pio_pkg::F_BAUD +: 3] <= pio_pkg::BAUD_MAX) begin
          baud_sel_o <= hwdata_i[pio_pkg::F_BAUD +: 3];
        end
        if (hwdata_i[pio_pkg::F_STN +: 7] <= pio_pkg::STN_MAX) begin
          station_o <= hwdata_i[pio_pkg::F_STN +: 7];
        end
      end
    end
  end

  // lockout indication, set wins over clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      lockind_r <= 1'b0;
    end else if (wr_key & locked) begin
      lockind_r <= 1'b1;
    end else if (wr_stat & hwdata_i[pio_pkg::S_LKIND]) begin
      lockind_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      psel_r <= pio_pkg::PH_FIRST;
    end else if (wr_psel) begin
      psel_r <= (|hwdata_i[31:6]) ? pio_pkg::PH_LAST : ph_clamp(hwdata_i[5:0]);
    end
  end

  pio_phase_mem u_mem (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .we_i       (wr_pdata),
    .waddr_i    (psel_r),
    .wdata_i    (hwdata_i[pio_pkg::ENT_W-1:0]),
    .raddr_i    ((st_r == pio_pkg::ST_IDLE) ? psel_r : cur_r),
    .rdata_o    (ent)
  );
  wire [2:0] e_func = ent[pio_pkg::E_FUNC +: 3];
  wire [5:0] e_par  = ent[pio_pkg::E_PAR +: 6];
  wire tick_end  = (tick_r == pio_pkg::TICK_LAST);
  wire step_done = ((st_r == pio_pkg::ST_PUMP) & phase_done_i) |
                   ((st_r == pio_pkg::ST_PAUSE) & tick_end & (pause_left_r == 6'h00));
  wire running   = (st_r != pio_pkg::ST_IDLE) & (st_r != pio_pkg::ST_BOOT);

  // Phase sequencer
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_r         <= pio_pkg::ST_BOOT;
      cur_r        <= pio_pkg::PH_FIRST;
      boot_r       <= 1'b1;
      rate_o       <= 16'h0000;
      dir_o        <= 1'b0;
      pause_left_r <= 6'h00;
      tick_r       <= 6'h00;
      start_p_r    <= 1'b0;
      stop_p_r     <= 1'b0;
    end else begin
      start_p_r <= 1'b0;
      stop_p_r  <= 1'b0;
      if (dir_fall) begin
        dir_o <= dircfg_r;
      end else if (dir_rise) begin
        dir_o <= ~dircfg_r;
      end
      tick_r <= (st_r == pio_pkg::ST_PAUSE && !tick_end) ? tick_r + 6'h01 : 6'h00;
      case (st_r)
        pio_pkg::ST_BOOT: begin
          st_r <= pio_pkg::ST_FETCH;
        end
        pio_pkg::ST_IDLE: begin
          if (cmd_start) begin
            cur_r     <= pio_pkg::PH_FIRST;
            st_r      <= pio_pkg::ST_FETCH;
            start_p_r <= 1'b1;
          end
        end
        pio_pkg::ST_FETCH: begin
          st_r <= pio_pkg::ST_EXEC;
        end
        pio_pkg::ST_EXEC: begin
          if (boot_r) begin
            boot_r <= 1'b0;
            if (e_func == pio_pkg::FN_PRSEL && lock_en_r) begin
              st_r      <= pio_pkg::ST_WAIT;
              start_p_r <= 1'b1;
            end else begin
              st_r <= pio_pkg::ST_IDLE;
            end
          end else begin
            case (e_func)
              pio_pkg::FN_RATE: begin
                rate_o <= ent[pio_pkg::E_RATE +: 16];
                dir_o  <= ent[pio_pkg::E_DIR];
                st_r   <= pio_pkg::ST_PUMP;
              end
              pio_pkg::FN_STOP: begin
                st_r     <= pio_pkg::ST_IDLE;
                stop_p_r <= 1'b1;
              end
              pio_pkg::FN_JUMP: begin
                cur_r <= ph_clamp(e_par);
                st_r  <= pio_pkg::ST_FETCH;
              end
              pio_pkg::FN_PAUSE: begin
                pause_left_r <= e_par;
                st_r         <= pio_pkg::ST_PAUSE;
              end
              pio_pkg::FN_PRSEL: begin
                st_r <= pio_pkg::ST_WAIT;
              end
              default: begin
                st_r <= pio_pkg::ST_IDLE;
                stop_p_r <= 1'b1;
              end
            endcase
          end
        end
        pio_pkg::ST_PAUSE: begin
          if (tick_end && pause_left_r != 6'h00) begin
            pause_left_r <= pause_left_r - 6'h01;
          end
        end
        pio_pkg::ST_WAIT: begin
          if (cmd_sel) begin
            cur_r <= ph_clamp(hwdata_i[pio_pkg::C_LABEL +: 6]);
            st_r  <= pio_pkg::ST_FETCH;
          end
        end
        pio_pkg::ST_PUMP: begin
          st_r <= pio_pkg::ST_PUMP;
        end
        default: begin
          st_r <= pio_pkg::ST_IDLE;
        end
      endcase
      // next consecutive phase; past 41 is a stop
      if (step_done) begin
        if (cur_r == pio_pkg::PH_LAST) begin
          st_r     <= pio_pkg::ST_IDLE;
          stop_p_r <= 1'b1;
        end else begin
          cur_r <= cur_r + 6'h01;
          st_r  <= pio_pkg::ST_FETCH;
        end
      end
      if (cmd_stop && running) begin
        st_r     <= pio_pkg::ST_IDLE;
        stop_p_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      motor_run_o <= 1'b0;
    end else begin
      // Mode 1 stays high across phase changes and waits, low only once stopped
      motor_run_o <= (st_r == pio_pkg::ST_PUMP) | (mmode_r & running);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ended_r    <= 1'b0;
      beep_cnt_r <= 22'h000000;
      beep_o     <= 1'b0;
    end else begin
      if (stop_p_r) begin
        ended_r <= 1'b1;
      end else if (wr_key | start_p_r) begin
        ended_r <= 1'b0;
      end
      if (wr_key) begin
        beep_cnt_r <= 22'(BEEP_CYC);
      end else if (beep_cnt_r != 22'h000000) begin
        beep_cnt_r <= beep_cnt_r - 22'h000001;
      end
      beep_o <= beep_en_r & ((beep_cnt_r != 22'h000000) | ended_r | (st_r == pio_pkg::ST_WAIT));
    end
  end

  wire fwd = (comm_r == pio_pkg::COMM_RECIP) | (comm_r == pio_pkg::COMM_DUAL);
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sec_start_o <= 1'b0;
      sec_stop_o  <= 1'b0;
      sec_rate_o  <= 16'h0000;
      sec_dir_o   <= 1'b1;
    end else begin
      sec_start_o <= (fwd & start_p_r) | ((comm_r == pio_pkg::COMM_ALT) & stop_p_r);
      sec_stop_o  <= fwd & stop_p_r;
      sec_rate_o  <= rate_o;
      sec_dir_o   <= (comm_r == pio_pkg::COMM_DUAL) ? dir_o : ~dir_o;
    end
  end

  // Read views of settings and status
  always_comb begin
    ctrl_rd = 32'h00000000;
    ctrl_rd[pio_pkg::F_DIRCFG] = dircfg_r;
    ctrl_rd[pio_pkg::F_MMODE]  = mmode_r;
    ctrl_rd[pio_pkg::F_LOCK]   = lock_en_r & plug;
    ctrl_rd[pio_pkg::F_BEEP]   = beep_en_r;
    ctrl_rd[pio_pkg::F_COMM +: 2] = comm_r;
    ctrl_rd[pio_pkg::F_BAUD +: 3] = baud_sel_o;
    ctrl_rd[pio_pkg::F_STN +: 7]  = station_o;
    stat_rd = 32'h00000000;
    stat_rd[pio_pkg::S_ST +: 3] = st_r;
    stat_rd[pio_pkg::S_PH +: 6] = cur_r;
    stat_rd[pio_pkg::S_DIR]     = dir_o;
    stat_rd[pio_pkg::S_MOTOR]   = motor_run_o;
    stat_rd[pio_pkg::S_LKIND]   = lockind_r;
    stat_rd[pio_pkg::S_PLUG]    = plug;
    stat_rd[pio_pkg::S_ENDED]   = ended_r;
    stat_rd[pio_pkg::S_BEEP]    = beep_o;
  end

  // Read data register, loaded in the wait cycle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h00000000;
    end else if (dp_rd_r) begin
      case (ap_addr_r)
        pio_pkg::A_CTRL, pio_pkg::A_KEY: hrdata_o <= ctrl_rd;
        pio_pkg::A_PSEL:  hrdata_o <= {26'h0000000, psel_r};
        pio_pkg::A_PDATA: hrdata_o <= {1'b0, ent};
        pio_pkg::A_STAT:  hrdata_o <= stat_rd;
        default:          hrdata_o <= 32'h00000000;
      endcase
    end
  end

  // Checks
  AST_M0_PAUSE_LOW: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !mmode_r && st_r == pio_pkg::ST_PAUSE |=> !motor_run_o) else $error("mode 0 output high in pause");
  AST_M1_PAUSE_HIGH: assert property (@(posedge core_clk_i) disable iff (rst_i)
    mmode_r && st_r == pio_pkg::ST_PAUSE |=> motor_run_o) else $error("mode 1 output low in pause");
  AST_LOCK_HOLDS: assert property (@(posedge core_clk_i) disable iff (rst_i)
    wr_key && locked && !wr_ctrl |=> $stable(station_o) && $stable(beep_en_r)) else $error("locked keypad write took");
  AST_SERIAL_TAKES: assert property (@(posedge core_clk_i) disable iff (rst_i)
    wr_ctrl |=> beep_en_r == $past(hwdata_i[pio_pkg::F_BEEP])) else $error("serial write lost");
  AST_LOCK_IND: assert property (@(posedge core_clk_i) disable iff (rst_i)
    wr_key && locked |=> lockind_r) else $error("lockout indication missing");
  AST_START_PH1: assert property (@(posedge core_clk_i) disable iff (rst_i)
    st_r == pio_pkg::ST_IDLE && cmd_start |=> st_r == pio_pkg::ST_FETCH && cur_r == pio_pkg::PH_FIRST ##1
    (st_r == pio_pkg::ST_EXEC || $past(cmd_stop))) else $error("start did not fetch phase 1");
  AST_PH_RANGE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cur_r <= pio_pkg::PH_LAST && psel_r <= pio_pkg::PH_LAST && cur_r != 6'h00) else $error("phase out of range");
  AST_STN_RANGE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    station_o <= pio_pkg::STN_MAX) else $error("station beyond 99");
  AST_WAIT_BEEP: assert property (@(posedge core_clk_i) disable iff (rst_i)
    beep_en_r && st_r == pio_pkg::ST_WAIT ##1 beep_en_r |-> beep_o) else $error("no beep awaiting start");
  AST_DUAL_DIR: assert property (@(posedge core_clk_i) disable iff (rst_i)
    comm_r == pio_pkg::COMM_DUAL ##1 $stable(dir_o) && comm_r == pio_pkg::COMM_DUAL |-> sec_dir_o == dir_o)
    else $error("dual direction mismatch");
  COV_RUN_PUMP: cover property (@(posedge core_clk_i) disable iff (rst_i)
    cmd_start ##[1:4] st_r == pio_pkg::ST_PUMP);
  COV_AUTORUN: cover property (@(posedge core_clk_i) disable iff (rst_i)
    boot_r && st_r == pio_pkg::ST_EXEC ##1 st_r == pio_pkg::ST_WAIT);
  COV_LOCKED_KEY: cover property (@(posedge core_clk_i) disable iff (rst_i) wr_key && locked);
endmodule

// >>> tb/pio_motor_model.sv
// Motor driver and secondary pump model facing the pump I/O block
`timescale 1ns/10ps
module pio_motor_model #(
  parameter int DONE_CYC = 8
) (
  input  wire logic core_clk_i,   // Core clock
  input  wire logic rst_i,        // Sync reset
  input  wire logic motor_run_i,  // Motor operating
  input  wire logic sec_start_i,  // Secondary start pulse
  input  wire logic sec_stop_i,   // Secondary stop pulse
  output logic      phase_done_o, // Phase finished
  output int        starts_o,     // Secondary starts seen
  output int        stops_o       // Secondary stops seen
);
  int cnt_r;
  // Motor runs a fixed number of cycles after its run input rises, then holds phase done while run stays high
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !motor_run_i)
      cnt_r <= 0;
    else if (cnt_r < DONE_CYC)
      cnt_r <= cnt_r + 1;
  end
  assign phase_done_o = motor_run_i && (cnt_r == DONE_CYC);
  // secondary side only counts the start and stop pulses sent to it
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      starts_o <= 0;
      stops_o  <= 0;
    end else begin
      if (sec_start_i)
        starts_o <= starts_o + 1;
      if (sec_stop_i)
        stops_o <= stops_o + 1;
    end
  end
endmodule

// >>> tb/tb.sv
// Self-checking bench for the pump I/O block
`timescale 1ns/10ps
module tb;
  logic        clk, rst, hsel, hwrite, dpin, pin_n, hrdy, hresp, mrun, beep, dir, sst, ssp, sdir, pdone, strap;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [15:0] rate, srate;
  logic [6:0]  stn;
  logic [2:0]  baud;
  int          miscompares, compares, cyc, starts, stops;
  pio_top #(.BEEP_CYC(20)) pio_top_inst (.core_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
    .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .dir_pin_i(dpin), .prog_in_n_i(pin_n),
    .lock_strap_i(strap), .phase_done_i(pdone), .motor_run_o(mrun), .beep_o(beep), .dir_o(dir),
    .rate_o(rate), .station_o(stn), .baud_sel_o(baud), .sec_start_o(sst), .sec_stop_o(ssp),
    .sec_rate_o(srate), .sec_dir_o(sdir));
  pio_motor_model pio_motor_model_inst (.core_clk_i(clk), .rst_i(rst), .motor_run_i(mrun),
    .sec_start_i(sst), .sec_stop_i(ssp), .phase_done_o(pdone), .starts_o(starts), .stops_o(stops));
  // Clock generation
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  task test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      test_done();
    end
  end
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Single AHB word transfer, read data left in q
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    // Address phase held until ready is seen high at a rising edge
    @(posedge clk);
    while (!hrdy) @(posedge clk);
    htrans <= 2'h0; hwdata <= d;
    // Data phase held likewise; read data taken at that same edge
    @(posedge clk);
    while (!hrdy) @(posedge clk);
    q = hrdata;
    hsel <= 1'b0;
    // One more edge so a written register has settled for the caller
    @(posedge clk);
  endtask
  task wmot(input logic v);
    int n;
    n = 0;
    while (mrun !== v && n < 40) begin
      @(negedge clk);
      n++;
    end
  endtask
  task t_reset;
    chk("station", 32'(stn), 32'h0);
    chk("baud", 32'(baud), 32'h4);
    chk("motor", 32'(mrun), 32'h0);
    chk("hresp", 32'(hresp), 32'h0);
  endtask
  task t_regs;
    for (int b = 0; b < 5; b++) begin
      bus(1'b1, pio_pkg::A_CTRL, 32'h0063_0000 | (32'(b) << 8));
      chk("baud_set", 32'(baud), 32'(b));
    end
    chk("station", 32'(stn), 32'h63);
    bus(1'b1, pio_pkg::A_CTRL, 32'h0064_0500);
    chk("stn_hi", 32'(stn), 32'h63);
    chk("baud_hi", 32'(baud), 32'h4);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", q, 32'h0);
  endtask
  task t_mem;
    bus(1'b1, pio_pkg::A_PSEL, 32'h32);
    bus(1'b1, pio_pkg::A_PDATA, 32'h0100_0029);
    bus(1'b1, pio_pkg::A_PSEL, 32'h29);
    bus(1'b0, pio_pkg::A_PDATA, 32'h0);
    chk("clamp", q, 32'h0100_0029);
    bus(1'b1, pio_pkg::A_PSEL, 32'h1);
    bus(1'b1, pio_pkg::A_PDATA, 32'h0100_1234);
    bus(1'b1, pio_pkg::A_PSEL, 32'h2);
    bus(1'b1, pio_pkg::A_PDATA, 32'h1000_0000);
  endtask
  task t_run(input logic [1:0] mode, input logic sd);
    int s0, p0;
    s0 = starts;
    p0 = stops;
    bus(1'b1, pio_pkg::A_CTRL, 32'h0000_0400 | (32'(mode) << 4));
    bus(1'b1, pio_pkg::A_CMD, 32'h1);
    wmot(1'b1);
    chk("motor_on", 32'(mrun), 32'h1);
    chk("rate", 32'(rate), 32'h1234);
    chk("dir", 32'(dir), 32'h1);
    repeat (2) @(negedge clk);
    chk("sec_rate", 32'(srate), 32'h1234);
    chk("sec_dir", 32'(sdir), 32'(sd));
    wmot(1'b0);
    bus(1'b0, pio_pkg::A_STAT, 32'h0);
    chk("ended", 32'(q[pio_pkg::S_ENDED]), 32'h1);
    chk("state", 32'(q[2:0]), 32'h1);
    chk("motor_off", 32'(mrun), 32'h0);
    chk("sec_starts", 32'(starts - s0), 32'h1);
    chk("sec_stops", 32'(stops - p0), 32'(mode != 2'h3));
  endtask
  task t_lock;
    bus(1'b1, pio_pkg::A_CTRL, 32'h0005_0404);
    bus(1'b0, pio_pkg::A_CTRL, 32'h0);
    chk("lock_hidden", q, 32'h0005_0400);
    bus(1'b1, pio_pkg::A_KEY, 32'h0007_0404);
    chk("key_blocked", 32'(stn), 32'h5);
    bus(1'b0, pio_pkg::A_STAT, 32'h0);
    chk("lock_ind", 32'(q[pio_pkg::S_LKIND]), 32'h1);
    bus(1'b1, pio_pkg::A_CTRL, 32'h0009_0404);
    chk("serial_ok", 32'(stn), 32'h9);
    bus(1'b1, pio_pkg::A_CMD, 32'h1);
    wmot(1'b1);
    chk("lock_start", 32'(mrun), 32'h1);
    wmot(1'b0);
    wt(1);
    pin_n <= 1'b0;
    wt(4010);
    bus(1'b0, pio_pkg::A_CTRL, 32'h0);
    chk("lock_shown", q, 32'h0009_0404);
  endtask
  task t_dir;
    dpin <= 1'b0;
    wt(4010);
    chk("fall_infuse", 32'(dir), 32'h0);
    dpin <= 1'b1;
    wt(4010);
    chk("rise_withdraw", 32'(dir), 32'h1);
    bus(1'b1, pio_pkg::A_CTRL, 32'h0009_0405);
    dpin <= 1'b0;
    wt(4010);
    chk("fall_swapped", 32'(dir), 32'h1);
    dpin <= 1'b1;
    wt(4010);
    chk("rise_swapped", 32'(dir), 32'h0);
  endtask
  // Auto-run after a reset taken while idle, wait beep, pause in motor mode 1
  task t_auto;
    bus(1'b1, pio_pkg::A_PSEL, 32'h1);
    bus(1'b1, pio_pkg::A_PDATA, 32'h4000_0000);
    bus(1'b1, pio_pkg::A_PSEL, 32'h3);
    bus(1'b1, pio_pkg::A_PDATA, 32'h3001_0000);
    bus(1'b1, pio_pkg::A_PSEL, 32'h4);
    bus(1'b1, pio_pkg::A_PDATA, 32'h1000_0000);
    rst <= 1'b1;
    wt(2);
    strap <= 1'b1;
    rst <= 1'b0;
    wt(4);
    bus(1'b1, pio_pkg::A_CTRL, 32'h0000_040E);
    bus(1'b0, pio_pkg::A_STAT, 32'h0);
    chk("auto_wait", 32'(q[2:0]), 32'h6);
    chk("wait_beep", 32'(q[pio_pkg::S_BEEP]), 32'h1);
    bus(1'b1, pio_pkg::A_CMD, 32'h0000_0304);
    bus(1'b0, pio_pkg::A_STAT, 32'h0);
    chk("pause_state", 32'(q[2:0]), 32'h5);
    chk("pause_motor", 32'(q[pio_pkg::S_MOTOR]), 32'h1);
    wt(100);
    bus(1'b0, pio_pkg::A_STAT, 32'h0);
    chk("end_state", 32'(q[2:0]), 32'h1);
    chk("end_beep", 32'(q[pio_pkg::S_BEEP]), 32'h1);
    chk("end_motor", 32'(q[pio_pkg::S_MOTOR]), 32'h0);
  endtask
  // Main sequence
  initial begin
    rst = 1'b1; hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0; haddr = 32'h0; hwdata = 32'h0;
    dpin = 1'b1; pin_n = 1'b1; strap = 1'b0;
    wt(2);
    rst <= 1'b0;
    wt(4);
    t_reset();
    t_regs();
    t_mem();
    t_run(2'h2, 1'b1);
    t_run(2'h1, 1'b0);
    t_run(2'h3, 1'b0);
    t_lock();
    t_dir();
    t_auto();
    test_done();
  end
endmodule
